//--- image_format_inquiry_regs_tb.sv
// Self-checking bench for the inquiry register bank
`include "imgfi_cfg.svh"

module image_format_inquiry_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import imgfi_pkg::*;
	typedef struct packed {
		logic [11:0] off;
		logic [31:0] exp;
		logic        er;
	} imgfi_row_s;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic color_i, req_i, done_i, pkt_wr_i, per_wr_i;
	logic start_w, refused_w, busy_w, blocked_w, e, g;
	logic [7:0] base_i, fmt_i;
	logic [2:0] speed_i;
	logic [15:0] pkt_i;
	logic [31:0] per_i, d;
	imgfi_geom_s win_i;
	imgfi_quad_req_s req_w;
	imgfi_quad_rsp_s rsp_w;
	imgfi_row_s rows [6];
	int err_count = 0;
	int check_count = 0;
	int i;

	initial forever #10 clk_i = ~clk_i;

	imgfi_regs DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .quad_req_i(req_w),
		.quad_rsp_o(rsp_w), .color_unit_i(color_i), .bayer_base_i(base_i),
		.region_window_i(win_i), .pixel_format_code_i(fmt_i),
		.bus_speed_i(speed_i), .packet_bytes_i(pkt_i),
		.packet_bytes_wr_i(pkt_wr_i), .period_cfg_wr_i(per_wr_i),
		.frame_period_i(per_i), .capture_req_i(req_i),
		.capture_done_i(done_i), .capture_start_o(start_w),
		.capture_refused_o(refused_w), .capture_busy_o(busy_w),
		.settings_blocked_o(blocked_w));
	imgfi_host_model host (.clk_i(clk_i), .quad_rsp_i(rsp_w),
		.quad_req_o(req_w));

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
		end
	endtask : check32
	task automatic check1(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: flag %b not %b", $time, got, exp);
		end
	endtask : check1
	task automatic rd(input logic [11:0] off, input logic [31:0] exp,
		input logic er);
		host.access(1'b0, off, 32'h0, d, e, g);
		if (g !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: no answer", $time);
			close_out();
		end else begin
			check32(d, exp);
			check1(e, er);
		end
	endtask : rd
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask : pulse
	task automatic cap(input logic ok);
		pulse(req_i);
		check1(start_w, ok);
		check1(refused_w, !ok);
		check1(blocked_w, !ok);
	endtask : cap
	task automatic pkt_set(input logic [15:0] v, input logic [31:0] exp);
		pkt_i = v;
		pulse(pkt_wr_i);
		rd(`IMGFI_OFS_CHECK, exp, 1'b0);
	endtask : pkt_set

	initial begin
		{color_i, req_i, done_i, pkt_wr_i, per_wr_i} = 5'h10;
		base_i = 8'h01;
		fmt_i = 8'h00;
		speed_i = 3'h1;
		pkt_i = 16'h0400;
		per_i = 32'h3d08_8889;
		win_i = '{16'h0002, 16'h0004, 16'h0064, 16'h0032};
		rows = '{'{12'h04c, 32'h0002_0002, 1'b0},
			'{12'h050, 32'h3d08_8889, 1'b0}, '{12'h054, 32'h0800_0000, 1'b0},
			'{12'h058, 32'h0100_0000, 1'b0}, '{12'h07c, 32'h8000_0000, 1'b0},
			'{12'h060, 32'h0000_0000, 1'b1}};
		repeat (16) @(negedge clk_i);
		check1(busy_w | start_w | blocked_w, 1'b0);
		rst_b_i = 1'b1;
		pulse(per_wr_i);
		foreach (rows[i])
			rd(rows[i].off, rows[i].exp, rows[i].er);
		host.access(1'b1, `IMGFI_OFS_POS_STEP, 32'hffff_ffff, d, e, g);
		check1(e, 1'b0);
		check32(d, 32'h0);
		rd(`IMGFI_OFS_POS_STEP, 32'h0002_0002, 1'b0);
		for (i = 0; i < 4; i++) begin
			base_i = i[7:0];
			rd(`IMGFI_OFS_BAYER, {i[7:0], 24'h0}, 1'b0);
		end
		// Odd origin flips the order and is a geometry fault
		win_i.col = 16'h0003;
		win_i.row = 16'h0005;
		rd(`IMGFI_OFS_BAYER, 32'h0000_0000, 1'b0);
		rd(`IMGFI_OFS_CHECK, 32'h8080_0000, 1'b0);
		cap(1'b0);
		win_i = '{16'h0002, 16'h0004, 16'h0064, 16'h0032};
		color_i = 1'b0;
		// Colour order lags the unit flag by one more stage than presence
		rd(`IMGFI_OFS_CHECK, 32'h0, 1'b0);
		rd(`IMGFI_OFS_BAYER, 32'h0, 1'b0);
		color_i = 1'b1;
		fmt_i = 8'h01;
		rd(`IMGFI_OFS_DEPTH, 32'h0, 1'b0);
		rd(`IMGFI_OFS_CHECK, 32'h8080_0000, 1'b0);
		fmt_i = 8'h00;
		speed_i = 3'h3;
		rd(`IMGFI_OFS_CHECK, 32'h8080_0000, 1'b0);
		speed_i = 3'h1;
		pkt_set(16'h0002, 32'h8040_0000);
		cap(1'b0);
		pkt_i = 16'h0400;
		rd(`IMGFI_OFS_CHECK, 32'h8040_0000, 1'b0);
		pkt_set(16'h1004, 32'h8040_0000);
		pkt_set(16'h1000, 32'h8000_0000);
		pkt_set(16'h0000, 32'h8040_0000);
		win_i = '{16'h0000, 16'h0000, 16'h0280, 16'h01e0};
		pkt_set(16'h0048, 32'h8040_0000);
		pkt_set(16'h004c, 32'h8000_0000);
		cap(1'b1);
		pulse(req_i);
		check1(start_w, 1'b0);
		check1(busy_w, 1'b1);
		pulse(done_i);
		check1(busy_w, 1'b0);
		// Period input alone is not a trigger
		per_i = 32'h3c88_8889;
		rd(`IMGFI_OFS_FRAME_PER, 32'h3d08_8889, 1'b0);
		pulse(per_wr_i);
		rd(`IMGFI_OFS_FRAME_PER, 32'h3c88_8889, 1'b0);
		per_i = 32'h3c08_8889;
		win_i.height = 16'h0100;
		// Period reload needs two edges after the window change
		@(negedge clk_i);
		rd(`IMGFI_OFS_FRAME_PER, 32'h3c08_8889, 1'b0);
		pkt_set(16'h0002, 32'h8040_0000);
		rst_b_i = 1'b0;
		@(negedge clk_i);
		check32(rsp_w.rdata, 32'h0);
		rst_b_i = 1'b1;
		rd(`IMGFI_OFS_CHECK, 32'h8000_0000, 1'b0);
		close_out();
	end
endmodule : image_format_inquiry_regs_tb

//--- imgfi_cfg.svh
// Constants for the image format inquiry register bank
`ifndef IMGFI_CFG_SVH
`define IMGFI_CFG_SVH

// Quadlet byte offsets
`define IMGFI_OFS_POS_STEP   12'h04c
`define IMGFI_OFS_FRAME_PER  12'h050
`define IMGFI_OFS_DEPTH      12'h054
`define IMGFI_OFS_BAYER      12'h058
`define IMGFI_OFS_CHECK      12'h07c

// Field places as vector indices; quadlet bit 0 is vector bit 31
`define IMGFI_COL_STEP_HI    31
`define IMGFI_COL_STEP_LO    16
`define IMGFI_ROW_STEP_HI    15
`define IMGFI_ROW_STEP_LO    0
`define IMGFI_DEPTH_HI       31
`define IMGFI_DEPTH_LO       24
`define IMGFI_BAYER_HI       31
`define IMGFI_BAYER_LO       24
`define IMGFI_PRESENCE_BIT   31
`define IMGFI_SETTING1_BIT   30
`define IMGFI_ERR_GEOM_BIT   23
`define IMGFI_ERR_PKT_BIT    22

// Fixed inquiry values
`define IMGFI_COL_STEP       16'h0002
`define IMGFI_ROW_STEP       16'h0002
`define IMGFI_POS_ALIGN_MASK 16'h0001
`define IMGFI_FMT_MONO8      8'h00
`define IMGFI_DEPTH_MONO8    8'h08
`define IMGFI_DEPTH_NONE     8'h00

// Colour order codes at the window origin
`define IMGFI_BAYER_RGGB     8'h00
`define IMGFI_BAYER_GBRG     8'h01
`define IMGFI_BAYER_GRBG     8'h02
`define IMGFI_BAYER_BGGR     8'h03
`define IMGFI_BAYER_NONE     8'h00

// Settings limits
`define IMGFI_BPP_UNIT_MASK  16'h0003
`define IMGFI_BPP_MAX        16'h1000
`define IMGFI_PKT_MAX        32'h0000_0fff
`define IMGFI_SENSOR_COLS    17'h0_0280
`define IMGFI_SENSOR_ROWS    17'h0_01e0
`define IMGFI_SPEED_MAX      3'h2

// Reset values
`define IMGFI_RST_WORD       32'h0000_0000
`define IMGFI_RST_FMT        8'h00
`define IMGFI_RST_SPEED      3'h0
`define IMGFI_RST_HALF       16'h0000

`endif

//--- imgfi_check.sv
// Settings checker producing the geometry and packet size error flags
`include "imgfi_cfg.svh"

module imgfi_check (
	input  wire logic                clk_i,
	input  wire logic                rst_b_i,
	input  wire imgfi_pkg::imgfi_geom_s geom_i,
	input  wire logic [7:0]          fmt_i,
	input  wire logic [2:0]          speed_i,
	input  wire logic [15:0]         bpp_i,
	input  wire logic                bpp_wr_i,
	output logic                     geom_err_o,
	output logic                     pkt_err_o
);
	import imgfi_pkg::*;

	logic        geom_err_r;
	logic        pkt_err_r;
	logic [16:0] col_end_w;
	logic [16:0] row_end_w;
	logic        align_bad_w;
	logic        size_bad_w;
	logic        fmt_bad_w;
	logic        speed_bad_w;
	logic        geom_bad_w;
	logic [31:0] frame_bytes_w;
	logic [31:0] capacity_w;
	logic        bpp_bad_w;

	assign col_end_w   = {1'b0, geom_i.col} + {1'b0, geom_i.width};
	assign row_end_w   = {1'b0, geom_i.row} + {1'b0, geom_i.height};
	assign align_bad_w = |((geom_i.col | geom_i.row) & `IMGFI_POS_ALIGN_MASK);
	assign size_bad_w  = (geom_i.width == `IMGFI_RST_HALF) ||
		(geom_i.height == `IMGFI_RST_HALF) ||
		(col_end_w > `IMGFI_SENSOR_COLS) ||
		(row_end_w > `IMGFI_SENSOR_ROWS);
	assign fmt_bad_w   = (fmt_i != `IMGFI_FMT_MONO8);
	assign speed_bad_w = (speed_i > `IMGFI_SPEED_MAX);
	// Bus speed, position, size and format judged together
	assign geom_bad_w  = align_bad_w | size_bad_w | fmt_bad_w | speed_bad_w;

	// One byte a pixel; other formats are already flagged above
	assign frame_bytes_w = {16'h0000, geom_i.width} * {16'h0000, geom_i.height};
	assign capacity_w    = {16'h0000, bpp_i} * `IMGFI_PKT_MAX;
	// Too many packets per frame counts as a bad packet size
	assign bpp_bad_w = (bpp_i == `IMGFI_RST_HALF) ||
		(|(bpp_i & `IMGFI_BPP_UNIT_MASK)) ||
		(bpp_i > `IMGFI_BPP_MAX) ||
		(capacity_w < frame_bytes_w);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			geom_err_r <= 1'b0;
			pkt_err_r  <= 1'b0;
		end else begin
			geom_err_r <= geom_bad_w;
			if (bpp_wr_i) begin
				pkt_err_r <= bpp_bad_w;
			end
		end
	end

	assign geom_err_o = geom_err_r;
	assign pkt_err_o  = pkt_err_r;

endmodule : imgfi_check

//--- imgfi_host_model.sv
// Host model issuing quadlet accesses to the register bank
module imgfi_host_model (
	input  wire logic                  clk_i,
	input  wire imgfi_pkg::imgfi_quad_rsp_s quad_rsp_i,
	output imgfi_pkg::imgfi_quad_req_s quad_req_o
);
	import imgfi_pkg::*;
	initial quad_req_o = '0;

	task automatic access(input logic wr, input logic [11:0] off,
		input logic [31:0] wd, output logic [31:0] rdata,
		output logic err, output logic got);
		int i;
		got = 1'b0;
		@(negedge clk_i);
		quad_req_o = '{rd: !wr, wr: wr, offset: off, wdata: wd};
		@(negedge clk_i);
		// Released lines inverted so a stale value cannot pass
		quad_req_o = '{rd: 1'b0, wr: 1'b0, offset: ~off, wdata: ~wd};
		for (i = 0; i < 4 && !got; i++) begin
			if (quad_rsp_i.ack === 1'b1) begin
				got = 1'b1;
				rdata = quad_rsp_i.rdata; // Bit 0 is vector bit 31
				err = quad_rsp_i.err;
			end else
				@(negedge clk_i);
		end
	endtask : access
endmodule : imgfi_host_model

//--- imgfi_pkg.sv
// Types shared by the image format inquiry register bank
package imgfi_pkg;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] offset;
		logic [31:0] wdata;
	} imgfi_quad_req_s;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} imgfi_quad_rsp_s;

	typedef struct packed {
		logic [15:0] col;
		logic [15:0] row;
		logic [15:0] width;
		logic [15:0] height;
	} imgfi_geom_s;

	typedef enum logic [1:0] {
		IMGFI_CAP_IDLE   = 2'b00,
		IMGFI_CAP_START  = 2'b01,
		IMGFI_CAP_REFUSE = 2'b10,
		IMGFI_CAP_RUN    = 2'b11
	} imgfi_cap_e;

endpackage : imgfi_pkg

//--- imgfi_regs.sv
// Image format inquiry and settings status registers with capture gate
`include "imgfi_cfg.svh"

module imgfi_regs (
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	input  wire imgfi_pkg::imgfi_quad_req_s quad_req_i,
	output imgfi_pkg::imgfi_quad_rsp_s  quad_rsp_o,
	input  wire logic                   color_unit_i,
	input  wire logic [7:0]             bayer_base_i,
	input  wire imgfi_pkg::imgfi_geom_s region_window_i,
	input  wire logic [7:0]             pixel_format_code_i,
	input  wire logic [2:0]             bus_speed_i,
	input  wire logic [15:0]            packet_bytes_i,
	input  wire logic                   packet_bytes_wr_i,
	input  wire logic                   period_cfg_wr_i,
	input  wire logic [31:0]            frame_period_i,
	input  wire logic                   capture_req_i,
	input  wire logic                   capture_done_i,
	output logic                        capture_start_o,
	output logic                        capture_refused_o,
	output logic                        capture_busy_o,
	output logic                        settings_blocked_o
);
	import imgfi_pkg::*;

	// Response and register state
	logic                   ack_r;
	logic                   ack_nxt;
	logic                   err_r;
	logic                   err_nxt;
	logic [31:0]            rdata_r;
	logic [31:0]            rdata_nxt;
	logic [31:0]            frame_period_r;
	logic                   period_load_r;
	logic [7:0]             depth_r;
	logic [7:0]             depth_nxt;
	logic [7:0]             bayer_r;
	logic [7:0]             bayer_nxt;
	logic                   color_r;
	imgfi_geom_s            geom_seen_r;
	logic [7:0]             fmt_seen_r;
	logic [2:0]             speed_seen_r;
	imgfi_cap_e             cap_state_r;
	imgfi_cap_e             cap_state_nxt;

	// Decode wires
	logic                   access_w;
	logic                   hit_pos_w;
	logic                   hit_period_w;
	logic                   hit_depth_w;
	logic                   hit_bayer_w;
	logic                   hit_check_w;
	logic                   hit_any_w;
	logic                   geom_err_w;
	logic                   pkt_err_w;
	logic                   blocked_w;
	logic                   period_change_w;
	logic [1:0]             origin_odd_w;
	logic [31:0]            word_pos_w;
	logic [31:0]            word_period_w;
	logic [31:0]            word_depth_w;
	logic [31:0]            word_bayer_w;
	logic [31:0]            word_check_w;

	imgfi_check u_check (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.geom_i     (region_window_i),
		.fmt_i      (pixel_format_code_i),
		.speed_i    (bus_speed_i),
		.bpp_i      (packet_bytes_i),
		.bpp_wr_i   (packet_bytes_wr_i),
		.geom_err_o (geom_err_w),
		.pkt_err_o  (pkt_err_w)
	);

	// Quadlet address decode
	assign access_w     = quad_req_i.rd | quad_req_i.wr;
	assign hit_pos_w    = (quad_req_i.offset == `IMGFI_OFS_POS_STEP);
	assign hit_period_w = (quad_req_i.offset == `IMGFI_OFS_FRAME_PER);
	assign hit_depth_w  = (quad_req_i.offset == `IMGFI_OFS_DEPTH);
	assign hit_bayer_w  = (quad_req_i.offset == `IMGFI_OFS_BAYER);
	assign hit_check_w  = (quad_req_i.offset == `IMGFI_OFS_CHECK);
	assign hit_any_w    = hit_pos_w | hit_period_w | hit_depth_w |
		hit_bayer_w | hit_check_w;

	// Read words; quadlet bit 0 sits on vector bit 31
	always_comb begin
		word_pos_w = `IMGFI_RST_WORD;
		word_pos_w[`IMGFI_COL_STEP_HI:`IMGFI_COL_STEP_LO] =
			`IMGFI_COL_STEP;
		word_pos_w[`IMGFI_ROW_STEP_HI:`IMGFI_ROW_STEP_LO] =
			`IMGFI_ROW_STEP;
	end

	assign word_period_w = frame_period_r;

	// Reserved bits of every word stay zero
	always_comb begin
		word_depth_w = `IMGFI_RST_WORD;
		word_depth_w[`IMGFI_DEPTH_HI:`IMGFI_DEPTH_LO] = depth_r;
	end

	always_comb begin
		word_bayer_w = `IMGFI_RST_WORD;
		word_bayer_w[`IMGFI_BAYER_HI:`IMGFI_BAYER_LO] = bayer_r;
	end

	// Bit 1 reads zero: dependent updates never wait on software
	always_comb begin
		word_check_w = `IMGFI_RST_WORD;
		word_check_w[`IMGFI_PRESENCE_BIT] = color_r;
		word_check_w[`IMGFI_SETTING1_BIT] = 1'b0;
		word_check_w[`IMGFI_ERR_GEOM_BIT] = geom_err_w;
		word_check_w[`IMGFI_ERR_PKT_BIT]  = pkt_err_w;
	end

	// Every register here is read-only; writes are acked and dropped
	always_comb begin
		ack_nxt   = access_w;
		err_nxt   = access_w & ~hit_any_w;
		rdata_nxt = `IMGFI_RST_WORD;
		if (quad_req_i.rd) begin
			case (1'b1)
				hit_pos_w:    rdata_nxt = word_pos_w;
				hit_period_w: rdata_nxt = word_period_w;
				hit_depth_w:  rdata_nxt = word_depth_w;
				hit_bayer_w:  rdata_nxt = word_bayer_w;
				hit_check_w:  rdata_nxt = word_check_w;
				default:      rdata_nxt = `IMGFI_RST_WORD;
			endcase
		end
	end

	// Depth from the pixel format; unknown codes read zero
	always_comb begin
		case (pixel_format_code_i)
			`IMGFI_FMT_MONO8: depth_nxt = `IMGFI_DEPTH_MONO8;
			default:          depth_nxt = `IMGFI_DEPTH_NONE;
		endcase
	end

	// Odd start column or row shifts the colour order by one pixel
	assign origin_odd_w = {region_window_i.col[0], region_window_i.row[0]};

	always_comb begin
		if (color_r) begin
			bayer_nxt = bayer_base_i ^ {6'h00, origin_odd_w};
		end else begin
			bayer_nxt = `IMGFI_BAYER_NONE;
		end
	end

	// A period write or a change of window, format or bus speed reloads the period two edges later
	assign period_change_w = period_cfg_wr_i |
		(region_window_i != geom_seen_r) |
		(pixel_format_code_i != fmt_seen_r) |
		(bus_speed_i != speed_seen_r);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_r   <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= `IMGFI_RST_WORD;
		end else begin
			ack_r   <= ack_nxt;
			err_r   <= err_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			geom_seen_r  <= '0;
			fmt_seen_r   <= `IMGFI_RST_FMT;
			speed_seen_r <= `IMGFI_RST_SPEED;
			period_load_r <= 1'b0;
		end else begin
			geom_seen_r  <= region_window_i;
			fmt_seen_r   <= pixel_format_code_i;
			speed_seen_r <= bus_speed_i;
			period_load_r <= period_change_w;
		end
	end

	// One cycle of slack lets the timing core settle its new period
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			frame_period_r <= `IMGFI_RST_WORD;
		end else if (period_load_r) begin
			frame_period_r <= frame_period_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			depth_r <= `IMGFI_DEPTH_NONE;
			bayer_r <= `IMGFI_BAYER_NONE;
			color_r <= 1'b0;
		end else begin
			depth_r <= depth_nxt;
			bayer_r <= bayer_nxt;
			color_r <= color_unit_i;
		end
	end

	// Capture gate
	assign blocked_w = geom_err_w | pkt_err_w;

	always_comb begin
		cap_state_nxt = cap_state_r;
		case (cap_state_r)
			IMGFI_CAP_IDLE: begin
				if (capture_req_i && blocked_w) begin
					cap_state_nxt = IMGFI_CAP_REFUSE;
				end else if (capture_req_i) begin
					cap_state_nxt = IMGFI_CAP_START;
				end
			end
			IMGFI_CAP_START: begin
				cap_state_nxt = IMGFI_CAP_RUN;
			end
			IMGFI_CAP_REFUSE: begin
				cap_state_nxt = IMGFI_CAP_IDLE;
			end
			IMGFI_CAP_RUN: begin
				if (capture_done_i) begin
					cap_state_nxt = IMGFI_CAP_IDLE;
				end
			end
			default: begin
				cap_state_nxt = IMGFI_CAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cap_state_r <= IMGFI_CAP_IDLE;
		end else begin
			cap_state_r <= cap_state_nxt;
		end
	end

	// A capture already running is not cut short by a late error
	assign capture_start_o    = (cap_state_r == IMGFI_CAP_START);
	assign capture_refused_o  = (cap_state_r == IMGFI_CAP_REFUSE);
	assign capture_busy_o     = (cap_state_r == IMGFI_CAP_START) |
		(cap_state_r == IMGFI_CAP_RUN);
	assign settings_blocked_o = blocked_w;

	assign quad_rsp_o.ack   = ack_r;
	assign quad_rsp_o.err   = err_r;
	assign quad_rsp_o.rdata = rdata_r;

endmodule : imgfi_regs

//--- imgfi_regs_properties.sv
// Concurrent checks on the inquiry register bank ports
`include "imgfi_cfg.svh"

module imgfi_regs_properties (
	input wire logic                   clk_i,
	input wire logic                   rst_b_i,
	input wire imgfi_pkg::imgfi_quad_req_s quad_req_i,
	input wire imgfi_pkg::imgfi_quad_rsp_s quad_rsp_o,
	input wire logic                   color_unit_i,
	input wire logic [7:0]             bayer_base_i,
	input wire imgfi_pkg::imgfi_geom_s region_window_i,
	input wire logic [7:0]             pixel_format_code_i,
	input wire logic [15:0]            packet_bytes_i,
	input wire logic                   packet_bytes_wr_i,
	input wire logic                   period_cfg_wr_i,
	input wire logic [31:0]            frame_period_i,
	input wire logic                   capture_req_i,
	input wire logic                   capture_start_o,
	input wire logic                   capture_refused_o,
	input wire logic                   capture_busy_o,
	input wire logic                   settings_blocked_o
);
	import imgfi_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic [31:0] rd_w = quad_rsp_o.rdata;
	wire logic idle_w = !capture_busy_o && !capture_refused_o;
	wire logic mapped_w = quad_req_i.offset inside {`IMGFI_OFS_POS_STEP,
		`IMGFI_OFS_FRAME_PER, `IMGFI_OFS_DEPTH, `IMGFI_OFS_BAYER,
		`IMGFI_OFS_CHECK};

	// Guard on the prior edge so values loaded during reset are not judged
	sequence s_read(logic [11:0] ofs);
		$past(rst_b_i) && quad_req_i.rd && quad_req_i.offset == ofs;
	endsequence
	sequence s_bad_pkt;
		packet_bytes_wr_i && packet_bytes_i[1:0] != 2'h0;
	endsequence

	a_pos_step_value: assert property (
		s_read(`IMGFI_OFS_POS_STEP) |=> rd_w == 32'h0002_0002)
		else $error("position step word wrong");
	a_period_latch: assert property (
		period_cfg_wr_i ##2 s_read(`IMGFI_OFS_FRAME_PER)
		|=> rd_w == $past(frame_period_i, 2))
		else $error("frame period not refreshed");
	a_depth_follows: assert property (
		s_read(`IMGFI_OFS_DEPTH) |=> rd_w == {($past(pixel_format_code_i,
		2) == 8'h00) ? 8'h08 : 8'h00, 24'h00_0000})
		else $error("depth word wrong");
	a_bayer_code: assert property (
		s_read(`IMGFI_OFS_BAYER) |=> rd_w == {$past(color_unit_i, 3) ?
		$past(bayer_base_i, 2) ^ {6'h00, $past(region_window_i.col[0], 2),
		$past(region_window_i.row[0], 2)} : 8'h00, 24'h00_0000})
		else $error("colour order word wrong");
	a_status_fixed: assert property (
		s_read(`IMGFI_OFS_CHECK) |=> rd_w[31] == $past(color_unit_i, 2)
		&& rd_w[30:24] == 7'h00 && rd_w[21:0] == 22'h00_0000)
		else $error("status fixed bits wrong");
	a_status_flags: assert property (
		s_read(`IMGFI_OFS_CHECK) |=> (rd_w[23] | rd_w[22]) ==
		$past(settings_blocked_o))
		else $error("status flags disagree with block");
	a_pkt_flag: assert property (
		s_bad_pkt ##1 !packet_bytes_wr_i ##1 s_read(`IMGFI_OFS_CHECK)
		|=> rd_w[22])
		else $error("packet flag not set");
	a_refuse_blocked: assert property (
		capture_req_i && idle_w && settings_blocked_o
		|=> capture_refused_o && !capture_start_o)
		else $error("blocked capture not refused");
	a_start_clear: assert property (
		capture_req_i && idle_w && !settings_blocked_o
		|=> capture_start_o && capture_busy_o && !capture_refused_o)
		else $error("clear capture not started");
	a_unmapped_err: assert property (
		(quad_req_i.rd || quad_req_i.wr) && !mapped_w
		|=> quad_rsp_o.ack && quad_rsp_o.err && rd_w == 32'h0)
		else $error("unmapped access not flagged");
endmodule : imgfi_regs_properties

bind imgfi_regs imgfi_regs_properties u_props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .quad_req_i(quad_req_i),
	.quad_rsp_o(quad_rsp_o), .color_unit_i(color_unit_i),
	.bayer_base_i(bayer_base_i), .region_window_i(region_window_i),
	.pixel_format_code_i(pixel_format_code_i),
	.packet_bytes_i(packet_bytes_i), .packet_bytes_wr_i(packet_bytes_wr_i),
	.period_cfg_wr_i(period_cfg_wr_i), .frame_period_i(frame_period_i),
	.capture_req_i(capture_req_i), .capture_start_o(capture_start_o),
	.capture_refused_o(capture_refused_o), .capture_busy_o(capture_busy_o),
	.settings_blocked_o(settings_blocked_o));
